/* File: rtl/adst_top.sv */
// Register side of the converter front end: DMA select, stamp timer,
// channel result FIFOs, interrupt status and an AXI4-Lite slave.
// Assumes samples and sample ticks are synchronous one-cycle strobes.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module adst_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_tick,
   input adst_pkg::adst_sample_type [adst_pkg::NUM_CH-1:0] sample_in,
   input wire logic [adst_pkg::NUM_CH-2:0] chan_pop,
   output logic [adst_pkg::NUM_CH-2:0][31:0] chan_result,
   output logic [adst_pkg::NUM_CH-1:0] dma_req,
   output logic irq
);

   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] offs);
      hit = (addr[7:2] == offs[7:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb,
                                         input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      merge = res & mask;
   endfunction

   function automatic logic [31:0] pack_result(
      input logic [adst_pkg::SAMPLE_W-1:0] smp,
      input logic [adst_pkg::STAMP_W-1:0] stamp);
      logic [31:0] w;
      w = 32'h0;
      w[adst_pkg::SAMPLE_LSB +: adst_pkg::SAMPLE_W] = smp;
      w[adst_pkg::STAMP_LSB +: adst_pkg::STAMP_W] = stamp;
      pack_result = w;
   endfunction

   logic [31:0] dma_sel_r;
   logic [31:0] timer_cfg_r;
   logic [31:0] irq_stat_r;
   logic [31:0] irq_stat_nxt;
   logic [31:0] irq_mask_r;
   logic [adst_pkg::STAMP_W-1:0] live_r;
   logic [adst_pkg::STAMP_W-1:0] live_nxt;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic rd_mapped;
   adst_pkg::adst_fifo_stat_type [adst_pkg::NUM_CH-1:0] fstat;
   logic [adst_pkg::NUM_CH-1:0] fifo_pop;
   logic [adst_pkg::NUM_CH-1:0] fifo_ovfl;
   logic [adst_pkg::NUM_CH-1:0] dma_bit;
   logic [adst_pkg::NUM_CH-1:0] ready_evt;
   logic [31:0] stat_set;
   logic [31:0] stat_clr;
   logic [11:0] levels;

   // Write channel: address and data taken together
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   wire rd_go = s_axi_arvalid && !rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   wire wr_dma = wr_go && hit(s_axi_awaddr, adst_pkg::DMA_SEL_OFFS);
   wire wr_tcfg = wr_go && hit(s_axi_awaddr, adst_pkg::TIMER_CFG_OFFS);
   wire wr_stat = wr_go && hit(s_axi_awaddr, adst_pkg::IRQ_STAT_OFFS);
   wire wr_mask = wr_go && hit(s_axi_awaddr, adst_pkg::IRQ_MASK_OFFS);
   wire wr_mapped = hit(s_axi_awaddr, adst_pkg::DMA_SEL_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::TIMER_CFG_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::IRQ_STAT_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::IRQ_MASK_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::TIMER_VAL_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::CH0_PORT_OFFS)
                 || hit(s_axi_awaddr, adst_pkg::FIFO_LVL_OFFS);
   wire rd_port = rd_go && hit(s_axi_araddr, adst_pkg::CH0_PORT_OFFS);

   // Timer configuration fields
   wire timer_run = timer_cfg_r[adst_pkg::TIMER_RUN_BIT];
   wire timer_clear = timer_cfg_r[adst_pkg::TIMER_CLEAR_BIT];
   wire [adst_pkg::STAMP_W-1:0] timer_limit =
      timer_cfg_r[adst_pkg::STAMP_W-1:0];

   // Stamp timer next value
   always_comb begin
      live_nxt = live_r;
      if (timer_clear) begin
         live_nxt = '0;
      end else if (timer_run && sample_tick) begin
         if (live_r == timer_limit) begin
            live_nxt = '0;
         end else begin
            live_nxt = live_r + 17'h1;
         end
      end
   end

   // Per-channel FIFOs, DMA selection and events
   assign fifo_pop[0] = rd_port;
   assign fifo_pop[adst_pkg::NUM_CH-1:1] = chan_pop;

   for (genvar c = 0; c < adst_pkg::NUM_CH; c++) begin : g_ch
      // Only even select bits act; odd ones are internal
      assign dma_bit[c] = dma_sel_r[2*c];
      assign dma_req[c] = dma_bit[c] && !fstat[c].empty;
      assign ready_evt[c] = sample_in[c].valid && !dma_bit[c];
      assign levels[3*c +: 3] = fstat[c].level;
      adst_fifo u_fifo (
         .aclk(aclk),
         .aresetn(aresetn),
         .push(sample_in[c].valid),
         .push_data(pack_result(sample_in[c].data, live_r)),
         .pop(fifo_pop[c]),
         .stat(fstat[c]),
         .overflow(fifo_ovfl[c])
      );
   end

   for (genvar c = 1; c < adst_pkg::NUM_CH; c++) begin : g_res
      assign chan_result[c-1] = fstat[c].head;
   end

   // Sticky status: set wins over a write-one clear
   assign stat_set = {24'h0, fifo_ovfl, ready_evt};
   assign stat_clr = wr_stat ? (s_axi_wdata & {{8{s_axi_wstrb[3]}},
                                {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                                {8{s_axi_wstrb[0]}}}) : 32'h0;
   assign irq_stat_nxt = ((irq_stat_r & ~stat_clr) | stat_set)
                       & adst_pkg::IRQ_MASK_BITS;
   assign irq = |(irq_stat_r & irq_mask_r);

   // Read data selection
   always_comb begin
      rdata_nxt = 32'h0;
      rd_mapped = 1'b1;
      if (hit(s_axi_araddr, adst_pkg::DMA_SEL_OFFS)) begin
         rdata_nxt = dma_sel_r;
      end else if (hit(s_axi_araddr, adst_pkg::TIMER_CFG_OFFS)) begin
         rdata_nxt = timer_cfg_r;
      end else if (hit(s_axi_araddr, adst_pkg::TIMER_VAL_OFFS)) begin
         rdata_nxt = {15'h0, live_r};
      end else if (hit(s_axi_araddr, adst_pkg::CH0_PORT_OFFS)) begin
         rdata_nxt = fstat[0].empty ? 32'h0 : fstat[0].head;
      end else if (hit(s_axi_araddr, adst_pkg::IRQ_STAT_OFFS)) begin
         rdata_nxt = irq_stat_r;
      end else if (hit(s_axi_araddr, adst_pkg::IRQ_MASK_OFFS)) begin
         rdata_nxt = irq_mask_r;
      end else if (hit(s_axi_araddr, adst_pkg::FIFO_LVL_OFFS)) begin
         rdata_nxt = {20'h0, levels};
      end else begin
         rd_mapped = 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_sel_r <= adst_pkg::DMA_SEL_RESET;
         timer_cfg_r <= adst_pkg::TIMER_CFG_RESET;
         irq_mask_r <= adst_pkg::IRQ_RESET;
         irq_stat_r <= adst_pkg::IRQ_RESET;
         live_r <= '0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         live_r <= live_nxt;
         if (wr_dma) begin
            dma_sel_r <= merge(dma_sel_r, s_axi_wdata, s_axi_wstrb,
                               adst_pkg::DMA_SEL_MASK);
         end
         if (wr_tcfg) begin
            timer_cfg_r <= merge(timer_cfg_r, s_axi_wdata, s_axi_wstrb,
                                 adst_pkg::TIMER_CFG_MASK);
         end
         if (wr_mask) begin
            irq_mask_r <= merge(irq_mask_r, s_axi_wdata, s_axi_wstrb,
                                adst_pkg::IRQ_MASK_BITS);
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= adst_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? adst_pkg::RESP_OKAY
                              : adst_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= adst_pkg::RESP_OKAY;
         rdata_r <= 32'h0;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_mapped ? adst_pkg::RESP_OKAY
                              : adst_pkg::RESP_SLVERR;
         rdata_r <= rdata_nxt;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule

/* File: rtl/adst_pkg.sv */
// Constants and carrier types for the converter DMA-select and stamp timer.
// Assumes one system clock and a synchronous active-low reset.
package adst_pkg;

   // Register byte offsets
   localparam logic [7:0] IRQ_STAT_OFFS = 8'h40;
   localparam logic [7:0] IRQ_MASK_OFFS = 8'h44;
   localparam logic [7:0] FIFO_LVL_OFFS = 8'h48;
   localparam logic [7:0] DMA_SEL_OFFS = 8'h64;
   localparam logic [7:0] TIMER_CFG_OFFS = 8'h68;
   localparam logic [7:0] TIMER_VAL_OFFS = 8'h70;
   localparam logic [7:0] CH0_PORT_OFFS = 8'h74;

   // Reset values and writable masks
   localparam logic [31:0] DMA_SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] DMA_SEL_MASK = 32'h0000_00ff;
   localparam logic [31:0] TIMER_CFG_RESET = 32'h0011_1111;
   localparam logic [31:0] TIMER_CFG_MASK = 32'h03ff_ffff;
   localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_BITS = 32'h0000_00ff;

   // Field positions
   localparam int TIMER_RUN_BIT = 25;
   localparam int TIMER_CLEAR_BIT = 24;
   localparam int STAMP_W = 17;
   localparam int SAMPLE_W = 12;
   localparam int SAMPLE_LSB = 2;
   localparam int STAMP_LSB = 14;
   localparam int STAT_READY_LSB = 0;
   localparam int STAT_OVFL_LSB = 4;

   // Channel and FIFO geometry
   localparam int NUM_CH = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int LVL_W = 3;
   localparam int WORD_W = 32;
   localparam logic [2:0] LVL_FULL = 3'h4;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One converted sample from a channel
   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] data;
   } adst_sample_type;

   // Result stream read side of one channel
   typedef struct packed {
      logic empty;
      logic [LVL_W-1:0] level;
      logic [WORD_W-1:0] head;
   } adst_fifo_stat_type;

endpackage

/* File: rtl/adst_fifo.sv */
// Four-word result FIFO of one converter channel.
// Assumes push and pop are one-cycle strobes on aclk.
`timescale 1ns/1ps
module adst_fifo (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic push,
   input wire logic [adst_pkg::WORD_W-1:0] push_data,
   input wire logic pop,
   output adst_pkg::adst_fifo_stat_type stat,
   output logic overflow
);
   logic [adst_pkg::WORD_W-1:0] mem_r [0:adst_pkg::FIFO_DEPTH-1];
   logic [1:0] wr_ptr_r;
   logic [1:0] rd_ptr_r;
   logic [adst_pkg::LVL_W-1:0] lvl_r;
   logic [adst_pkg::LVL_W-1:0] lvl_nxt;
   wire full = (lvl_r == adst_pkg::LVL_FULL);
   wire empty = (lvl_r == 3'h0);
   wire do_pop = pop && !empty;
   wire do_push = push && (!full || do_pop);

   // Level stays within zero to four
   assign lvl_nxt = lvl_r + {2'h0, do_push} - {2'h0, do_pop};
   assign overflow = push && !do_push;
   assign stat.empty = empty;
   assign stat.level = lvl_r;
   assign stat.head = mem_r[rd_ptr_r];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
         lvl_r <= 3'h0;
      end else begin
         lvl_r <= lvl_nxt;
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 2'h1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < adst_pkg::FIFO_DEPTH; i++) begin
            mem_r[i] <= 32'h0;
         end
      end else if (do_push) begin
         mem_r[wr_ptr_r] <= push_data;
      end
   end
endmodule

/* File: verif/adst_top_asserts.sv */
// Checker of read fields, request lines and the interrupt output.
// Assumes binding to adst_top, one clock and synchronous reset.
`timescale 1ns/1ps
module adst_top_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input adst_pkg::adst_sample_type [adst_pkg::NUM_CH-1:0] sample_in,
   input wire logic [adst_pkg::NUM_CH-2:0] chan_pop,
   input wire logic [adst_pkg::NUM_CH-1:0] dma_req,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd_take;
   logic wr_take;
   logic any_push;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign wr_take = s_axi_awvalid && s_axi_awready;
   assign any_push = sample_in[0].valid || sample_in[1].valid ||
                     sample_in[2].valid || sample_in[3].valid;
   AST_SEL_READ: assert property (rd_take && s_axi_araddr == 8'h64 |=>
      s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0)
      else $error("select upper bits not zero");
   AST_CFG_READ: assert property (rd_take && s_axi_araddr == 8'h68 |=>
      s_axi_rdata[31:26] == 6'h0) else $error("config reserved bits set");
   AST_VAL_READ: assert property (rd_take && s_axi_araddr == 8'h70 |=>
      s_axi_rdata[31:17] == 15'h0) else $error("timer upper bits set");
   AST_WORD_READ: assert property (rd_take && s_axi_araddr == 8'h74 |=>
      s_axi_rdata[31] == 1'h0 && s_axi_rdata[1:0] == 2'h0)
      else $error("result word reserved bits set");
   AST_REQ_HOLD: assert property (dma_req[1] && !chan_pop[0] && !wr_take
      |=> dma_req[1]) else $error("request dropped without drain");
   AST_REQ_QUIET: assert property (!dma_req[0] && !wr_take &&
      !sample_in[0].valid |=> !dma_req[0]) else $error("request from nothing");
   AST_REQ_RISE: assert property ($rose(dma_req[0]) |->
      $past(sample_in[0].valid) || $past(wr_take))
      else $error("request rose without cause");
   AST_REQ_FALL: assert property ($fell(dma_req[0]) |->
      $past(rd_take) || $past(wr_take)) else $error("request fell early");
   AST_IRQ_CAUSE: assert property ($rose(irq) |->
      $past(wr_take) || $past(any_push)) else $error("irq without event");
   CVR_WRITE: cover property (wr_take);
   CVR_PORT_READ: cover property (rd_take && s_axi_araddr == 8'h74);
   CVR_DMA_REQ: cover property ($rose(dma_req[1]));
endmodule
bind adst_top adst_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .sample_in, .chan_pop, .dma_req, .irq);

/* File: verif/adst_dma_sink.sv */
// DMA side model: pops channels 1, 2 and 3 while their request stands and stall is low.
// Assumes one idle cycle after each pop for the request to settle.
`timescale 1ns/1ps
module adst_dma_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stall,
   input wire logic [3:0] dma_req,
   output logic [2:0] chan_pop
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_pop <= 3'h0;
      end else begin
         chan_pop <= stall ? 3'h0 : dma_req[3:1] & ~chan_pop;
      end
   end
endmodule

/* File: verif/adst_top_tb.sv */
// Bench of adst_top: register rows, reset values, timer, FIFO and DMA.
// Assumes the DMA sink model drains channels 1, 2 and 3.
`timescale 1ns/1ps
module adst_top_tb;
   typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;}
      adst_row_type;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_rvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_arready, irq, sample_tick, stall;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [3:0] dma_req;
   logic [2:0] chan_pop;
   logic [2:0][31:0] chan_result;
   adst_pkg::adst_sample_type [3:0] sample_in;
   int bad_count, check_count, cyc, n;
   adst_row_type rows [4] = '{'{8'h64, 32'hffffffff, 32'h000000ff, 2'h0},
      '{8'h68, 32'hffffffff, 32'h03ffffff, 2'h0},
      '{8'h70, 32'hffffffff, 32'h00000000, 2'h0},
      '{8'h60, 32'h12345678, 32'h00000000, 2'h2}};
   adst_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sample_tick, .sample_in, .chan_pop, .chan_result,
      .dma_req, .irq);
   adst_dma_sink u_sink (.aclk, .aresetn, .stall, .dma_req, .chan_pop);
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Address and data each held until their own ready
      while (!aw_done || !w_done) begin
         @(posedge aclk);
         aw_done = aw_done || s_axi_awready;
         w_done = w_done || s_axi_wready;
         if (aw_done) begin
            s_axi_awvalid <= 1'b0;
         end
         if (w_done) begin
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      @(posedge aclk iff s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = adst_pkg::RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk iff s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      @(posedge aclk iff s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(v, e);
      chk(32'(r), 32'(er));
   endtask
   task automatic push(input int c, input logic [11:0] s);
      sample_in[c] <= '{1'b1, s};
      @(posedge aclk);
      sample_in[c].valid <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic reset_dut;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         $display("Error t=%0t cycles %h limit %h", $time, cyc, 4000);
         wrap_up();
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, sample_tick, aresetn} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      sample_in = '0;
      stall = 1'b1;
      reset_dut();
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].d);
         chk(32'(r), 32'(rows[i].r));
         rdc(rows[i].a, rows[i].e, rows[i].r);
      end
      $display("test register rows done");
      reset_dut();
      rdc(adst_pkg::DMA_SEL_OFFS, adst_pkg::DMA_SEL_RESET);
      rdc(adst_pkg::TIMER_CFG_OFFS, adst_pkg::TIMER_CFG_RESET);
      rdc(adst_pkg::TIMER_VAL_OFFS, 32'h0);
      rdc(adst_pkg::CH0_PORT_OFFS, 32'h0);
      axw(adst_pkg::TIMER_CFG_OFFS, 32'h02fe0003);
      repeat (6) begin
         sample_tick <= 1'b1;
         @(posedge aclk);
         sample_tick <= 1'b0;
         @(posedge aclk);
      end
      rdc(adst_pkg::TIMER_VAL_OFFS, 32'h2);
      $display("test reset and timer done");
      push(0, 12'habc);
      chk(32'(dma_req), 32'h0);
      chk(32'(irq), 32'h0);
      axw(adst_pkg::IRQ_MASK_OFFS, 32'h1);
      chk(32'(irq), 32'h1);
      rdc(adst_pkg::CH0_PORT_OFFS, {1'b0, 17'h2, 12'habc, 2'h0});
      rdc(adst_pkg::CH0_PORT_OFFS, 32'h0);
      axw(adst_pkg::IRQ_STAT_OFFS, 32'h1);
      chk(32'(irq), 32'h0);
      $display("test interrupt mode done");
      axw(adst_pkg::DMA_SEL_OFFS, 32'h1);
      repeat (5) push(0, 12'h5a5);
      chk(32'(dma_req), 32'h1);
      rdc(adst_pkg::FIFO_LVL_OFFS, 32'h4);
      rdc(adst_pkg::IRQ_STAT_OFFS, 32'h10);
      axw(adst_pkg::IRQ_STAT_OFFS, 32'h10);
      rdc(adst_pkg::IRQ_STAT_OFFS, 32'h0);
      // Overflow and its clear on the same edge: the overflow stays
      fork
         push(0, 12'h5a5);
         axw(adst_pkg::IRQ_STAT_OFFS, 32'h10);
      join
      rdc(adst_pkg::IRQ_STAT_OFFS, 32'h10);
      repeat (4) rdc(adst_pkg::CH0_PORT_OFFS, {1'b0, 17'h2, 12'h5a5, 2'h0});
      chk(32'(dma_req), 32'h0);
      $display("test overflow and drain done");
      axw(adst_pkg::DMA_SEL_OFFS, 32'h000000ae);
      push(0, 12'h111);
      push(1, 12'h222);
      chk(32'(dma_req), 32'h2);
      chk(chan_result[0], {1'b0, 17'h2, 12'h222, 2'h0});
      stall <= 1'b0;
      for (n = 0; n < 20 && dma_req[1]; n++) @(posedge aclk);
      chk(32'(dma_req), 32'h0);
      axw(adst_pkg::TIMER_CFG_OFFS, 32'h01000003);
      rdc(adst_pkg::TIMER_VAL_OFFS, 32'h0);
      $display("test select bits and clear done");
      wrap_up();
   end
endmodule
